// ===== verilog/vsd_regs.svh
// Constants for the two-wire DAC front end
// Assumes inclusion by both ends and the bench
`ifndef VSD_REGS_SVH
`define VSD_REGS_SVH
`define VSD_ADDR_HI5      5'h1D
`define VSD_ADDR_HI6      6'h3B
`define VSD_GCALL_ADDR    8'h00
`define VSD_GCALL_RESET   8'h06
`define VSD_HS_CODE       5'h01
`define VSD_CMD_ACQUIRE   3'h1
`define VSD_CMD_OTP       3'h2
`define VSD_MID_SCALE     10'h200
`define VSD_ZERO_CODE     10'h000
`define VSD_OTP_SLOTS     4
`define VSD_BITS_BYTE     4'h8
`define VSD_LINK_DIV      6
`endif

// ===== verilog/vsd_pkg.sv
// Types used by the slave end
// Assumes vsd_regs.svh holds the constants
`default_nettype none
package vsd_pkg;
  typedef enum logic [3:0] {
    VSD_IDLE, VSD_ADDR, VSD_ADDR_ACK, VSD_WR_BYTE, VSD_WR_ACK, VSD_RD_BYTE, VSD_RD_ACK, VSD_IGNORE
  } vsd_state_e;
  typedef enum logic [1:0] {
    VSD_OP_DAC, VSD_OP_OTP, VSD_OP_ACQ, VSD_OP_READ
  } vsd_op_e;
endpackage
`default_nettype wire

// ===== verilog/vsd_bus_if.sv
// Two-wire bus joining master and slave ends
// Assumes the bench resolves the open-drain wires from the enables
`timescale 1ns/1ps
`default_nettype none
interface vsd_bus_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl_line;
  logic sda_line;
  modport slave (input scl_line, input sda_line, output sda_o_s, output sda_oe_s);
  modport master (input scl_line, input sda_line, output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m);
endinterface
`default_nettype wire

// ===== verilog/vsd_slave.sv
// Slave end: two-wire front end of a 10-bit DAC with OTP memory
// Assumes bus lines arrive asynchronously; straps are static pins
`timescale 1ns/1ps
`default_nettype none
`include "vsd_regs.svh"
module vsd_slave #(
  parameter bit TEN_PIN = 1'b1
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       addr_strap_low_i,
  input  wire logic       addr_strap_high_i,
  vsd_bus_if.slave        bus,
  output logic [9:0]      dac_code_o,
  output logic [3:0]      otp_status_o,
  output logic            hs_mode_o
);
  // ==========================================================================
  // Synchronisers and line events
  logic [1:0] scl_s_q, sda_s_q, stl_s_q, sth_s_q;
  logic       scl_d1_q, sda_d1_q;
  always_ff @(posedge clock_i) begin
    scl_s_q  <= {scl_s_q[0], bus.scl_line};
    sda_s_q  <= {sda_s_q[0], bus.sda_line};
    stl_s_q  <= {stl_s_q[0], addr_strap_low_i};
    sth_s_q  <= {sth_s_q[0], addr_strap_high_i};
    scl_d1_q <= scl_s_q[1];
    sda_d1_q <= sda_s_q[1];
  end
  wire scl_rise = scl_s_q[1] & ~scl_d1_q;
  wire scl_fall = ~scl_s_q[1] & scl_d1_q;
  wire start_ev = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
  wire stop_ev  = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];

  // ==========================================================================
  // Decoding
  logic [7:0]  shift_q;
  logic [3:0]  bitcnt_q;
  logic [7:0]  upper_q;
  logic [1:0]  nbytes_q;
  logic        gcall_q;
  logic [9:0]  otp_mem_q [`VSD_OTP_SLOTS];
  logic [3:0]  therm_q;
  logic        hs_q;
  logic [9:0]  dac_q;
  logic        sda_oe_q;
  logic        boot_q;
  logic        gc_reset_q;
  vsd_pkg::vsd_state_e st_q;

  wire [7:0] rx_byte   = {shift_q[6:0], sda_s_q[1]};
  wire [6:0] my_addr   = TEN_PIN ? {`VSD_ADDR_HI5, sth_s_q[1], stl_s_q[1]}
                                 : {`VSD_ADDR_HI6, stl_s_q[1]};
  wire       addr_hit  = shift_q[7:1] == my_addr;
  wire       gcall_hit = shift_q == `VSD_GCALL_ADDR;
  wire       hs_code   = shift_q[7:3] == `VSD_HS_CODE;
  wire [2:0] cmd       = upper_q[7:5];
  wire       last_bit  = bitcnt_q == `VSD_BITS_BYTE;
  wire [9:0] otp_last  = therm_q[3] ? otp_mem_q[3] : therm_q[2] ? otp_mem_q[2]
                       : therm_q[1] ? otp_mem_q[1] : otp_mem_q[0];
  wire [2:0] slot      = therm_q[2] ? 3'h3 : therm_q[1] ? 3'h2 : therm_q[0] ? 3'h1 : 3'h0;
  wire [15:0] rd_word  = {therm_q, 2'h0, dac_q};
  wire       do_reset  = ~rst_n_i | gc_reset_q;
  wire       acq_go    = st_q == vsd_pkg::VSD_WR_BYTE && nbytes_q == 2'h1 && !gcall_q
                       && cmd == `VSD_CMD_ACQUIRE;

  // ==========================================================================
  // OTP storage survives the general-call reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      therm_q <= 4'h0;
      for (int i = 0; i < `VSD_OTP_SLOTS; i++) otp_mem_q[i] <= `VSD_ZERO_CODE;
    end else if (st_q == vsd_pkg::VSD_WR_BYTE && nbytes_q == 2'h1 && last_bit && scl_fall && !gcall_q
                 && cmd == `VSD_CMD_OTP && !therm_q[3]) begin
      otp_mem_q[slot[1:0]] <= {upper_q[1:0], shift_q};
      therm_q <= {therm_q[2:0], 1'b1};
    end
  end

  // ==========================================================================
  // Protocol engine
  always_ff @(posedge clock_i) begin
    if (do_reset) begin
      st_q       <= vsd_pkg::VSD_IDLE;
      shift_q    <= 8'h00;
      bitcnt_q   <= 4'h0;
      upper_q    <= 8'h00;
      nbytes_q   <= 2'h0;
      gcall_q    <= 1'b0;
      hs_q       <= 1'b0;
      sda_oe_q   <= 1'b0;
      gc_reset_q <= 1'b0;
      boot_q     <= 1'b1;
      dac_q      <= `VSD_MID_SCALE;
    end else begin
      if (boot_q) begin
        boot_q <= 1'b0;
        dac_q  <= therm_q[0] ? otp_last : `VSD_MID_SCALE;
      end
      if (stop_ev) begin
        st_q     <= vsd_pkg::VSD_IDLE;
        hs_q     <= 1'b0;
        sda_oe_q <= 1'b0;
        if (acq_go)
          dac_q <= therm_q[0] ? otp_last : `VSD_ZERO_CODE;
      end else if (start_ev) begin
        st_q     <= vsd_pkg::VSD_ADDR;
        bitcnt_q <= 4'h0;
        nbytes_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          vsd_pkg::VSD_ADDR, vsd_pkg::VSD_WR_BYTE: begin
            if (scl_rise) begin
              shift_q  <= rx_byte;
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            if (scl_fall && last_bit) begin
              bitcnt_q <= 4'h0;
              if (st_q == vsd_pkg::VSD_ADDR) begin
                gcall_q <= gcall_hit;
                if (hs_code && !gcall_hit) begin
                  hs_q <= 1'b1;
                  st_q <= vsd_pkg::VSD_IGNORE;
                end else if (addr_hit || gcall_hit) begin
                  sda_oe_q <= 1'b1;
                  st_q     <= vsd_pkg::VSD_ADDR_ACK;
                end else begin
                  st_q <= vsd_pkg::VSD_IGNORE;
                end
              end else begin
                if (nbytes_q == 2'h0) upper_q <= shift_q;
                nbytes_q <= nbytes_q + 2'h1;
                st_q     <= vsd_pkg::VSD_WR_ACK;
                if (gcall_q) begin
                  sda_oe_q <= shift_q == `VSD_GCALL_RESET;
                end else begin
                  sda_oe_q <= 1'b1;
                  if (nbytes_q == 2'h1 && cmd != `VSD_CMD_ACQUIRE)
                    dac_q <= {upper_q[1:0], shift_q};
                end
              end
            end
          end
          vsd_pkg::VSD_ADDR_ACK: if (scl_fall) begin
            if (shift_q[0] && !gcall_q) begin
              st_q     <= vsd_pkg::VSD_RD_BYTE;
              sda_oe_q <= nbytes_q[0] ? ~rd_word[7] : ~rd_word[15];
              bitcnt_q <= 4'h1;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= vsd_pkg::VSD_WR_BYTE;
            end
          end
          vsd_pkg::VSD_WR_ACK: if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (gcall_q && sda_oe_q) gc_reset_q <= 1'b1;
            st_q <= (gcall_q && !sda_oe_q) ? vsd_pkg::VSD_IGNORE : vsd_pkg::VSD_WR_BYTE;
          end
          vsd_pkg::VSD_RD_BYTE: if (scl_fall) begin
            if (last_bit) begin
              sda_oe_q <= 1'b0;
              st_q     <= vsd_pkg::VSD_RD_ACK;
            end else begin
              sda_oe_q <= nbytes_q[0] ? ~rd_word[4'h7 - bitcnt_q[2:0]] : ~rd_word[4'hF - bitcnt_q];
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
          vsd_pkg::VSD_RD_ACK: if (scl_rise) begin
            if (sda_s_q[1] || nbytes_q[0]) st_q <= vsd_pkg::VSD_IGNORE;
            else begin
              nbytes_q <= 2'h1;
              st_q     <= vsd_pkg::VSD_ADDR_ACK;
              bitcnt_q <= 4'h0;
            end
          end
          vsd_pkg::VSD_IDLE, vsd_pkg::VSD_IGNORE: ;
          default: st_q <= vsd_pkg::VSD_IDLE;
        endcase
      end
    end
  end

  // Second read byte reuses the read path through the acknowledge state
  assign bus.sda_o_s  = 1'b0;
  assign bus.sda_oe_s = sda_oe_q;
  always_ff @(posedge clock_i) begin
    dac_code_o   <= dac_q;
    otp_status_o <= therm_q;
    hs_mode_o    <= hs_q;
  end
endmodule // vsd_slave
`default_nettype wire

// ===== verilog/vsd_master.sv
// Master end: issues one two-wire transaction per request
// Assumes a single-cycle request strobe from user logic
`timescale 1ns/1ps
`default_nettype none
`include "vsd_regs.svh"
module vsd_master #(
  parameter int DIV = `VSD_LINK_DIV
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [7:0] addr_byte_i,
  input  wire logic [1:0] nbytes_i,
  input  wire logic [15:0] wdata_i,
  vsd_bus_if.master       bus,
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic [15:0]     rdata_o
);
  // ==========================================================================
  // Quarter-period tick and bit sequencer
  logic [7:0]  div_q;
  logic [1:0]  ph_q;
  logic [5:0]  bit_q;
  logic [26:0] sh_q;
  logic [5:0]  total_q;
  logic        scl_q, sda_q, busy_q;
  logic [1:0]  sdi_q;
  wire tick = div_q == 8'(DIV - 1);
  wire [5:0] nbits = 6'd9 + 6'(9 * nbytes_i);
  always_ff @(posedge clock_i) begin
    sdi_q <= {sdi_q[0], bus.sda_line};
    if (!rst_n_i) begin
      div_q <= 8'h00; ph_q <= 2'h0; bit_q <= 6'h00; sh_q <= '0; total_q <= 6'h00;
      scl_q <= 1'b1; sda_q <= 1'b1; busy_q <= 1'b0;
      done_o <= 1'b0; nack_o <= 1'b0; rdata_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      div_q  <= tick ? 8'h00 : div_q + 8'h01;
      if (!busy_q) begin
        if (req_i) begin
          busy_q  <= 1'b1;
          div_q   <= 8'h00;
          sda_q   <= 1'b0;
          total_q <= nbits;
          bit_q   <= 6'h00;
          ph_q    <= 2'h0;
          nack_o  <= 1'b0;
          sh_q    <= {addr_byte_i, 1'b1, wdata_i[15:8], ~addr_byte_i[0], wdata_i[7:0], 1'b1};
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: scl_q <= 1'b0;
          2'h1: sda_q <= bit_q == total_q ? 1'b0 : sh_q[26];
          2'h2: scl_q <= 1'b1;
          default: begin
            if (bit_q == total_q) begin
              sda_q <= 1'b1;
              busy_q <= 1'b0;
              done_o <= 1'b1;
            end else begin
              if (bit_q == 6'd8 && sdi_q[1]) nack_o <= 1'b1;
              if (addr_byte_i[0] && bit_q > 6'd8 && bit_q != 6'd17 && bit_q != total_q - 6'h01)
                rdata_o <= {rdata_o[14:0], sdi_q[1]};
              sh_q  <= {sh_q[25:0], 1'b1};
              bit_q <= bit_q + 6'h01;
            end
          end
        endcase
      end
    end
  end
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = ~scl_q;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = ~sda_q;
  assign busy_o = busy_q;
endmodule // vsd_master
`default_nettype wire

// ===== verif/vsd_bus_asserts.sv
// Checker of the shared two-wire bus
// Assumes resolved lines from the bench and a divider of 4
`timescale 1ns/1ps
`default_nettype none
module vsd_bus_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic sda_oe_m,
  input wire logic sda_o_s,
  input wire logic sda_oe_s
);
  // ====================
  // Frame tracking
  logic       scl_q;
  logic       sda_q;
  logic [4:0] cnt_q;
  logic [7:0] sh_q;
  wire        start_w = scl_line && scl_q && sda_q && !sda_line;
  wire        rise_w  = scl_line && !scl_q;
  always_ff @(posedge clock_i) begin
    scl_q <= scl_line;
    sda_q <= sda_line;
    if (!rst_n_i || start_w) cnt_q <= 5'h00;
    else if (rise_w && cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
    if (rise_w && cnt_q < 5'h08) sh_q <= {sh_q[6:0], sda_line};
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence ninth_s; rise_w && cnt_q == 5'h08; endsequence
  sequence hs_code_s; ninth_s ##0 sh_q[7:3] == 5'h01; endsequence
  sequence gcall_s; ninth_s ##0 sh_q == 8'h00; endsequence
  drive_low_a: assert property (sda_oe_s |-> !sda_o_s)
    else $error("slave drives sda high");
  ack_hold_a: assert property ($rose(sda_oe_s) |-> sda_oe_s [*4])
    else $error("slave sda pulse too short");
  quiet_high_a: assert property ($changed(sda_oe_s) |-> !scl_line)
    else $error("slave sda moved with scl high");
  start_own_a: assert property (start_w |-> sda_oe_m && !sda_oe_s)
    else $error("start not made by master");
  addr_quiet_a: assert property (scl_line && scl_q && cnt_q inside {[1:8]} |-> !sda_oe_s)
    else $error("slave drove sda in address bits");
  hs_noack_a: assert property (hs_code_s |-> !sda_oe_s [*2])
    else $error("master code acknowledged");
  gcall_ack_a: assert property (gcall_s |-> sda_oe_s)
    else $error("general call not acknowledged");
  master_hold_a: assert property ($rose(scl_line) |-> $stable(sda_oe_m) [*3])
    else $error("master sda moved with scl high");
  scl_high_a: assert property ($rose(scl_line) |-> scl_line [*3])
    else $error("scl high phase too short");
endmodule // vsd_bus_asserts
`default_nettype wire

// ===== verif/test_i2c_dac_otp_slave_interface.sv
// Bench joining master and slave ends over one bus
// Assumes ten-pin addressing and a divider of 4
`timescale 1ns/1ps
`default_nettype none
`include "vsd_regs.svh"
module test_i2c_dac_otp_slave_interface;
  typedef struct {logic n; logic [9:0] d; logic [3:0] s; logic [15:0] r; bit rd;} vsd_note_s;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, req_i = 1'b0, lo_i = 1'b0, hi_i = 1'b0, hs_seen = 1'b0;
  logic [7:0]  addr_byte_i = 8'h00, sa;
  logic [1:0]  nbytes_i = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [9:0]  dac_e, otp_e, v;
  logic [3:0]  stat_e;
  wire logic   busy_o, done_o, nack_o, hs_mode_o;
  wire logic [9:0]  dac_code_o;
  wire logic [3:0]  otp_status_o;
  wire logic [15:0] rdata_o;
  int          err_count = 0, cmp_count = 0, i;
  vsd_note_s   q[$];
  logic [7:0]  bad_flip [3] = '{8'h02, 8'h04, 8'h40};
  // ====================
  // Bus, ends and checker
  vsd_bus_if bus_if ();
  assign bus_if.scl_line = ~bus_if.scl_oe_m;
  assign bus_if.sda_line = ~(bus_if.sda_oe_m | bus_if.sda_oe_s);
  always #2.5 clock_i = ~clock_i;
  vsd_master #(.DIV(4)) vsd_master_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
    .addr_byte_i(addr_byte_i), .nbytes_i(nbytes_i), .wdata_i(wdata_i), .bus(bus_if.master),
    .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
  vsd_slave vsd_slave_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_strap_low_i(lo_i),
    .addr_strap_high_i(hi_i), .bus(bus_if.slave), .dac_code_o(dac_code_o),
    .otp_status_o(otp_status_o), .hs_mode_o(hs_mode_o));
  vsd_bus_asserts vsd_bus_asserts_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .scl_line(bus_if.scl_line), .sda_line(bus_if.sda_line), .sda_oe_m(bus_if.sda_oe_m),
    .sda_o_s(bus_if.sda_o_s), .sda_oe_s(bus_if.sda_oe_s));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic [1:0] n, input logic [15:0] w, input logic ne,
                      input bit rd);
    int t;
    @(negedge clock_i);
    addr_byte_i = a;
    nbytes_i = n;
    wdata_i = w;
    req_i = 1'b1;
    q.push_back(vsd_note_s'{ne, dac_e, stat_e, {stat_e, 2'b00, dac_e}, rd});
    @(negedge clock_i);
    req_i = 1'b0;
    check(16'(busy_o), 16'h0001);
    for (t = 0; t < 4000 && done_o !== 1'b1; t++) @(negedge clock_i);
    if (done_o !== 1'b1) err_count++;
    repeat (20) @(negedge clock_i);
  endtask
  task automatic dac_wr;
    v = 10'($urandom);
    dac_e = v;
    xfer(sa, 2'h2, {1'b1, 5'($urandom), v}, 1'b0, 1'b0);
  endtask
  // ====================
  // Result watcher
  initial forever begin : mon
    vsd_note_s e;
    @(negedge clock_i iff done_o === 1'b1);
    repeat (12) @(negedge clock_i);
    e = q.pop_front();
    check(16'(nack_o), 16'(e.n));
    check(16'(dac_code_o), 16'(e.d));
    check(16'(otp_status_o), 16'(e.s));
    if (e.rd) check(rdata_o, e.r);
  end
  always @(negedge clock_i) if (hs_mode_o === 1'b1) hs_seen <= 1'b1;
  initial begin : dog
    #300us;
    err_count++;
    end_of_test();
  end
  // ====================
  // Main sequence
  initial begin : main
    i = $urandom(6379);
    lo_i = 1'($urandom);
    hi_i = 1'($urandom);
    sa = {`VSD_ADDR_HI5, hi_i, lo_i, 1'b0};
    dac_e = `VSD_MID_SCALE;
    otp_e = `VSD_ZERO_CODE;
    stat_e = 4'h0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check(16'(dac_code_o), 16'(`VSD_MID_SCALE));
    dac_wr();
    foreach (bad_flip[k]) xfer(sa ^ bad_flip[k], 2'h2, 16'h8155, 1'b1, 1'b0);
    xfer(sa, 2'h1, 16'h8300, 1'b0, 1'b0);
    dac_e = `VSD_ZERO_CODE;
    xfer(sa, 2'h1, {3'b001, 5'($urandom), 8'h00}, 1'b0, 1'b0);
    dac_e = `VSD_MID_SCALE;
    xfer(`VSD_GCALL_ADDR, 2'h1, {`VSD_GCALL_RESET, 8'h00}, 1'b0, 1'b0);
    xfer({`VSD_HS_CODE, 3'($urandom)}, 2'h0, 16'h0000, 1'b1, 1'b0);
    check(16'(hs_seen), 16'h0001);
    check(16'(hs_mode_o), 16'h0000);
    for (i = 0; i < `VSD_OTP_SLOTS; i++) begin
      v = 10'($urandom);
      dac_e = v;
      otp_e = v;
      stat_e = {stat_e[2:0], 1'b1};
      xfer(sa, 2'h2, {6'b010000, v}, 1'b0, 1'b0);
      xfer(sa | 8'h01, 2'h2, 16'hFFFF, 1'b0, 1'b1);
    end
    v = 10'($urandom);
    dac_e = v;
    xfer(sa, 2'h2, {6'b010000, v}, 1'b0, 1'b0);
    dac_wr();
    dac_e = otp_e;
    xfer(sa, 2'h1, {3'b001, 5'($urandom), 8'h00}, 1'b0, 1'b0);
    dac_wr();
    xfer(`VSD_GCALL_ADDR, 2'h1, 16'h0500, 1'b0, 1'b0);
    dac_e = otp_e;
    xfer(`VSD_GCALL_ADDR, 2'h1, {`VSD_GCALL_RESET, 8'h00}, 1'b0, 1'b0);
    end_of_test();
  end
endmodule // test_i2c_dac_otp_slave_interface
`default_nettype wire
